// File: include/bpp_pkg.sv
package bpp_pkg;

   // data widths
   localparam int DW        = 22;
   localparam int CNT_W     = 16;
   localparam int LUT_DEPTH = 64;

   // apb register byte offsets
   localparam logic [11:0] OFF_INPUT_CTRL  = 12'h000;
   localparam logic [11:0] OFF_STATS_CTRL  = 12'h004;
   localparam logic [11:0] OFF_OUTPUT_CTRL = 12'h008;
   localparam logic [11:0] OFF_NORM_CTRL   = 12'h00C;
   localparam logic [11:0] OFF_ACCESS_CTRL = 12'h010;
   localparam logic [11:0] OFF_THR_BUFFER  = 12'h014;
   localparam logic [11:0] OFF_THR_COPY    = 12'h018;
   localparam logic [11:0] OFF_CNT_BUFFER  = 12'h01C;
   localparam logic [11:0] OFF_CNT_COPY    = 12'h020;
   localparam logic [11:0] OFF_UPPER_SAT   = 12'h024;
   localparam logic [11:0] OFF_LOWER_SAT   = 12'h028;
   localparam logic [11:0] OFF_PRESC_CTRL  = 12'h02C;
   localparam logic [11:0] OFF_LUT_BASE    = 12'h100;
   localparam logic [11:0] OFF_LUT_LAST    = 12'h1FC;

   // reset values
   localparam logic [7:0]  RST_CTRL        = 8'h00;
   localparam logic [7:0]  RST_ACCESS_CTRL = 8'h02;
   localparam logic [23:0] RST_THRESHOLD   = 24'h200000;

   // field positions
   localparam int IC_CAS_SEL   = 0;
   localparam int IC_SHIFT_LO  = 1;
   localparam int IC_RECT_LO   = 6;
   localparam int NC_ADD_Y     = 1;
   localparam int NC_DYN_SEL   = 2;
   localparam int NC_SHIFT_LO  = 3;
   localparam int OC_BYTE_HI   = 5;
   localparam int OC_BYTE_LO   = 6;
   localparam int AC_LUT_EN    = 1;
   localparam int THR_POS_OVF  = 22;
   localparam int THR_NEG_OVF  = 23;
   localparam int Y_SHIFT_LO   = 22;
   localparam int CC_LOAD      = 0;

   // shift limits
   localparam int IN_SHIFT_MAX    = 8;
   localparam int NORM_RIGHT_MAX  = 14;
   localparam int NORM_LEFT_MAX   = 2;
   localparam int PRESC_POS_MAX   = 14;

   // overflow limits of the 22 bit signed sum
   localparam logic signed [23:0] SUM_MAX = 24'sh1FFFFF;
   localparam logic signed [23:0] SUM_MIN = -24'sh200000;
   localparam logic [DW-1:0]      X_MOST_NEG = 22'h200000;

   typedef enum logic [1:0] {
      BPP_MIN_REG   = 2'b00,
      BPP_MAX_REG   = 2'b01,
      BPP_UNDER_CNT = 2'b10,
      BPP_OVER_CNT  = 2'b11
   } bpp_stat_mode_t;

   typedef enum logic [1:0] {
      BPP_RECT_PASS  = 2'b00,
      BPP_RECT_FULL  = 2'b01,
      BPP_RECT_HALF  = 2'b10,
      BPP_RECT_PASS2 = 2'b11
   } bpp_rect_mode_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } bpp_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } bpp_apb_rsp_t;

endpackage

// File: core/bpp_backend.sv
`timescale 1ns/1ps
// Behaviour
// RULE1: input shifter moves up to 8, left unchecked
// RULE2: right shifts produce a rounding bit
// RULE3: cascade adder sums shift, round, cascade/zero
// RULE4: flag sums beyond the 22 bit signed range
// RULE5: rectifier passes, full or half wave
// RULE6: full wave leaves most negative value unchanged
// RULE7: two bit field selects statistics mode
// RULE8: max/min mode tracks extreme, counts updates
// RULE9: no threshold update on overflow cycles
// RULE10: overshoot/undershoot modes count threshold crossings
// RULE11: event counter saturates instead of wrapping
// RULE12: sticky overflow bits cleared via copy write
// RULE13: processor reaches threshold/count through buffers only
// RULE14: prescaler picks 8 bit table address field
// RULE15: lost significant bits raise over/underselect
// RULE16: 64 word table, word and byte select
// RULE17: saturation words on overflow, byte three forced
// RULE18: table access bit low zeroes table bus
// RULE19: normaliser shifts right 14, left 2, else zero
// RULE20: normaliser shift from register or table bits
// RULE21: output adder adds normaliser, round, table/zero
// RULE22: table byte optionally drives upper/lower output bits
module bpp_backend (
   input  wire logic                  ref_clk_i,
   input  wire logic                  sys_rst_i,
   input  wire logic                  clk_en_i,
   input  wire bpp_pkg::bpp_apb_req_t apb_req_i,
   output bpp_pkg::bpp_apb_rsp_t      apb_rsp_o,
   input  wire logic [21:0]           mac_data_i,
   input  wire logic [21:0]           cas_in_i,
   input  wire logic                  in_valid_i,
   output logic [21:0]                cas_out_o,
   output logic                       out_valid_o
);
   import bpp_pkg::*;

   logic [7:0]       input_ctrl_reg_q;
   logic [7:0]       stats_ctrl_reg_q;
   logic [7:0]       output_ctrl_reg_q;
   logic [7:0]       norm_ctrl_reg_q;
   logic [7:0]       access_ctrl_reg_q;
   logic [4:0]       presc_pos_q;
   logic [23:0]      extreme_threshold_reg_q;
   logic [CNT_W-1:0] event_count_reg_q;
   logic [23:0]      threshold_buffer_q;
   logic [CNT_W-1:0] count_buffer_q;
   logic [31:0]      upper_saturation_word_q;
   logic [31:0]      lower_saturation_word_q;
   logic [31:0]      lut_mem [LUT_DEPTH];
   bpp_apb_rsp_t     rsp_q;
   logic [21:0]      cas_out_q;
   logic             out_valid_q;

   // apb decode
   logic        apb_do;
   logic        wr_en;
   logic        lut_hit;
   logic        lut_open;
   logic [31:0] rd_data;
   logic        rd_err;

   // a write lands only on the edge that sees pready high
   assign apb_do   = apb_req_i.psel & apb_req_i.penable & rsp_q.pready;
   assign wr_en    = apb_do & apb_req_i.pwrite & clk_en_i;
   assign lut_hit  = (apb_req_i.paddr >= OFF_LUT_BASE) && (apb_req_i.paddr <= OFF_LUT_LAST);
   assign lut_open = ~access_ctrl_reg_q[AC_LUT_EN];

   // read mux; table words read as zero while the table is live
   always_comb begin
      rd_data = 32'h0;
      rd_err  = 1'b0;
      if (apb_req_i.paddr == OFF_INPUT_CTRL) begin
         rd_data = {24'h0, input_ctrl_reg_q};
      end else if (apb_req_i.paddr == OFF_STATS_CTRL) begin
         rd_data = {24'h0, stats_ctrl_reg_q};
      end else if (apb_req_i.paddr == OFF_OUTPUT_CTRL) begin
         rd_data = {24'h0, output_ctrl_reg_q};
      end else if (apb_req_i.paddr == OFF_NORM_CTRL) begin
         rd_data = {24'h0, norm_ctrl_reg_q};
      end else if (apb_req_i.paddr == OFF_ACCESS_CTRL) begin
         rd_data = {24'h0, access_ctrl_reg_q};
      end else if (apb_req_i.paddr == OFF_THR_BUFFER) begin
         rd_data = {8'h00, threshold_buffer_q};                       // [RULE13]
      end else if (apb_req_i.paddr == OFF_THR_COPY) begin
         rd_data = 32'h0;
      end else if (apb_req_i.paddr == OFF_CNT_BUFFER) begin
         rd_data = {{(32-CNT_W){1'b0}}, count_buffer_q};               // [RULE13]
      end else if (apb_req_i.paddr == OFF_CNT_COPY) begin
         rd_data = 32'h0;
      end else if (apb_req_i.paddr == OFF_UPPER_SAT) begin
         rd_data = lut_open ? upper_saturation_word_q : 32'h00000000;  // [RULE18]
      end else if (apb_req_i.paddr == OFF_LOWER_SAT) begin
         rd_data = lut_open ? lower_saturation_word_q : 32'h00000000;  // [RULE18]
      end else if (apb_req_i.paddr == OFF_PRESC_CTRL) begin
         rd_data = {27'h0, presc_pos_q};
      end else if (lut_hit) begin
         rd_data = lut_open ? lut_mem[apb_req_i.paddr[7:2]] : 32'h0;
      end else begin
         rd_err  = 1'b1;
      end
   end

   // one wait state: pready rises on the second access cycle
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rsp_q <= '0;
      end else if (clk_en_i) begin
         rsp_q.pready  <= apb_req_i.psel & apb_req_i.penable & ~rsp_q.pready;
         rsp_q.prdata  <= (apb_req_i.psel & apb_req_i.penable & ~apb_req_i.pwrite) ? rd_data : 32'h00000000;
         rsp_q.pslverr <= apb_req_i.psel & apb_req_i.penable & ~rsp_q.pready & rd_err;
      end
   end

   // plain control registers
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         input_ctrl_reg_q  <= RST_CTRL;
         stats_ctrl_reg_q  <= RST_CTRL;
         output_ctrl_reg_q <= RST_CTRL;
         norm_ctrl_reg_q   <= RST_CTRL;
         access_ctrl_reg_q <= RST_ACCESS_CTRL;
         presc_pos_q       <= 5'h00;
      end else if (wr_en) begin
         if (apb_req_i.paddr == OFF_INPUT_CTRL) begin
            input_ctrl_reg_q <= apb_req_i.pwdata[7:0];
         end else if (apb_req_i.paddr == OFF_STATS_CTRL) begin
            stats_ctrl_reg_q <= apb_req_i.pwdata[7:0];
         end else if (apb_req_i.paddr == OFF_OUTPUT_CTRL) begin
            output_ctrl_reg_q <= apb_req_i.pwdata[7:0];
         end else if (apb_req_i.paddr == OFF_NORM_CTRL) begin
            norm_ctrl_reg_q <= apb_req_i.pwdata[7:0];
         end else if (apb_req_i.paddr == OFF_ACCESS_CTRL) begin
            access_ctrl_reg_q <= apb_req_i.pwdata[7:0];
         end else if (apb_req_i.paddr == OFF_PRESC_CTRL) begin
            presc_pos_q <= apb_req_i.pwdata[4:0];
         end
      end
   end

   // table and saturation words; writable only while the table is parked
   always_ff @(posedge ref_clk_i) begin
      if (wr_en && lut_open && lut_hit) begin
         lut_mem[apb_req_i.paddr[7:2]] <= apb_req_i.pwdata;            // [RULE18]
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         upper_saturation_word_q <= 32'h00000000;
         lower_saturation_word_q <= 32'h00000000;
      end else if (wr_en && lut_open) begin
         if (apb_req_i.paddr == OFF_UPPER_SAT) begin
            upper_saturation_word_q <= apb_req_i.pwdata;               // [RULE18]
         end else if (apb_req_i.paddr == OFF_LOWER_SAT) begin
            lower_saturation_word_q <= apb_req_i.pwdata;
         end
      end
   end

   // input block
   logic signed [4:0]  in_shift;
   logic [3:0]         in_amt;
   logic signed [22:0] in_wide;
   logic signed [21:0] sh_out;
   logic               in_rnd;
   logic signed [23:0] sum;
   logic               pos_ovf;
   logic               neg_ovf;
   logic [21:0]        add_out;
   logic [21:0]        x_bus;

   // positive field shifts left, negative right, clamped at eight places
   always_comb begin
      in_shift = input_ctrl_reg_q[IC_SHIFT_LO +: 5];
      in_amt   = 4'h0;
      in_wide  = {$signed(mac_data_i), 1'b0};
      sh_out   = $signed(mac_data_i);
      in_rnd   = 1'b0;
      if (in_shift >= 0) begin
         in_amt = (in_shift > IN_SHIFT_MAX) ? 4'(IN_SHIFT_MAX) : 4'(in_shift);
         sh_out = $signed(mac_data_i) <<< in_amt;                      // [RULE1] overflow unchecked
      end else begin
         in_amt  = (-in_shift > IN_SHIFT_MAX) ? 4'(IN_SHIFT_MAX) : 4'(-in_shift);
         in_wide = $signed({mac_data_i, 1'b0}) >>> in_amt;
         sh_out  = in_wide[22:1];
         in_rnd  = in_wide[0];                                         // [RULE2] last bit shifted out
      end
   end

   // three input cascade sum at 24 bits so overflow is visible
   assign sum = 24'(sh_out) + (input_ctrl_reg_q[IC_CAS_SEL] ? 24'($signed(cas_in_i)) : 24'sh000000)
                + $signed({23'h000000, in_rnd});                       // [RULE3]
   assign pos_ovf = sum > SUM_MAX;                                     // [RULE4]
   assign neg_ovf = sum < SUM_MIN;                                     // [RULE4]
   assign add_out = sum[21:0];

   // rectifier feeding the result bus
   always_comb begin
      x_bus = add_out;
      case (bpp_rect_mode_t'(input_ctrl_reg_q[IC_RECT_LO +: 2]))      // [RULE5]
         BPP_RECT_FULL: begin
            if (add_out[21] && add_out != X_MOST_NEG) begin            // [RULE6]
               x_bus = 22'(-$signed(add_out));
            end
         end
         BPP_RECT_HALF: begin
            if (add_out[21]) begin
               x_bus = 22'h000000;
            end
         end
         default: x_bus = add_out;
      endcase
   end

   // statistics monitor
   logic           above;
   logic           below;
   logic           upd_thr;
   logic           bump;
   logic           thr_copy_wr;
   logic           cnt_copy_wr;

   assign above = $signed(x_bus) > $signed(extreme_threshold_reg_q[21:0]);
   assign below = $signed(x_bus) < $signed(extreme_threshold_reg_q[21:0]);
   assign thr_copy_wr = wr_en && (apb_req_i.paddr == OFF_THR_COPY);
   assign cnt_copy_wr = wr_en && (apb_req_i.paddr == OFF_CNT_COPY);

   // mode decode: threshold update and counter bump per sample
   always_comb begin
      upd_thr = 1'b0;
      bump    = 1'b0;
      case (bpp_stat_mode_t'(stats_ctrl_reg_q[1:0]))                   // [RULE7]
         BPP_MAX_REG: begin
            upd_thr = above & ~pos_ovf & ~neg_ovf;                     // [RULE8] [RULE9]
            bump    = upd_thr;
         end
         BPP_MIN_REG: begin
            upd_thr = below & ~pos_ovf & ~neg_ovf;                     // [RULE8] [RULE9]
            bump    = upd_thr;
         end
         BPP_OVER_CNT:  bump = above | pos_ovf;                        // [RULE10]
         BPP_UNDER_CNT: bump = below;                                  // [RULE10]
         default: bump = 1'b0;
      endcase
      upd_thr = upd_thr & in_valid_i;
      bump    = bump & in_valid_i;
   end

   // threshold plus sticky overflow bits; a fresh overflow beats the clear
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         extreme_threshold_reg_q <= RST_THRESHOLD;
      end else if (clk_en_i) begin
         if (thr_copy_wr) begin
            extreme_threshold_reg_q <= {2'b00, threshold_buffer_q[21:0]}; // [RULE12] [RULE13]
         end else if (upd_thr) begin
            extreme_threshold_reg_q[21:0] <= x_bus;                       // [RULE8]
         end
         if (in_valid_i && pos_ovf) begin
            extreme_threshold_reg_q[THR_POS_OVF] <= 1'b1;                 // [RULE12]
         end
         if (in_valid_i && neg_ovf) begin
            extreme_threshold_reg_q[THR_NEG_OVF] <= 1'b1;                 // [RULE12]
         end
      end
   end

   // saturating event counter, loadable from its buffer
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         event_count_reg_q <= '0;
      end else if (clk_en_i) begin
         if (cnt_copy_wr && apb_req_i.pwdata[CC_LOAD]) begin
            event_count_reg_q <= count_buffer_q;                       // [RULE13]
         end else if (bump && event_count_reg_q != {CNT_W{1'b1}}) begin
            event_count_reg_q <= event_count_reg_q + 1'b1;             // [RULE11]
         end
      end
   end

   // buffers: software writes, or a snapshot of the live registers
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         threshold_buffer_q <= '0;
         count_buffer_q     <= '0;
      end else if (wr_en) begin
         if (apb_req_i.paddr == OFF_THR_BUFFER) begin
            threshold_buffer_q <= apb_req_i.pwdata[23:0];
         end else if (apb_req_i.paddr == OFF_CNT_BUFFER) begin
            count_buffer_q <= apb_req_i.pwdata[CNT_W-1:0];
         end else if (cnt_copy_wr && !apb_req_i.pwdata[CC_LOAD]) begin
            threshold_buffer_q <= extreme_threshold_reg_q;             // [RULE13]
            count_buffer_q     <= event_count_reg_q;
         end
      end
   end

   // data transformation unit
   logic [4:0]         presc_pos;
   logic signed [21:0] presc_hi;
   logic [7:0]         lut_addr;
   logic               over_sel;
   logic               under_sel;
   logic               sat_hi;
   logic               sat_lo;
   logic [31:0]        word;
   logic [31:0]        y_bus;
   logic [1:0]         byte_sel;
   logic [7:0]         tbl_byte;

   // the field's top bit and all bits above it must copy the sign, else the field is lossy
   always_comb begin
      presc_pos = (presc_pos_q > 5'(PRESC_POS_MAX)) ? 5'(PRESC_POS_MAX) : presc_pos_q;
      lut_addr  = 8'(x_bus >> presc_pos);                              // [RULE14]
      presc_hi  = $signed(x_bus) >>> (presc_pos + 5'd7);
      over_sel  = !x_bus[21] && presc_hi != 22'sh000000;               // [RULE15]
      under_sel = x_bus[21] && presc_hi != -22'sh000001;               // [RULE15]
   end

   assign sat_hi = pos_ovf | over_sel;                                  // [RULE17]
   assign sat_lo = ~sat_hi & (neg_ovf | under_sel);                     // [RULE17]

   // word and byte selection with saturation override
   always_comb begin
      if (sat_hi) begin
         word     = upper_saturation_word_q;                           // [RULE17]
         byte_sel = 2'd3;
      end else if (sat_lo) begin
         word     = lower_saturation_word_q;
         byte_sel = 2'd3;
      end else begin
         word     = lut_mem[lut_addr[7:2]];                            // [RULE16]
         byte_sel = lut_addr[1:0];                                     // [RULE16]
      end
      y_bus    = lut_open ? 32'h00000000 : word;                       // [RULE18]
      tbl_byte = y_bus[byte_sel*8 +: 8];
   end

   // normaliser and output stage
   logic signed [4:0]  norm_shift;
   logic signed [22:0] norm_wide;
   logic signed [21:0] norm_out;
   logic               norm_rnd;
   logic [21:0]        out_sum;
   logic [21:0]        cas_d;

   // table-driven shift only while the table is live
   always_comb begin
      norm_shift = (norm_ctrl_reg_q[NC_DYN_SEL] && !lut_open) ? y_bus[Y_SHIFT_LO +: 5]
                                                               : norm_ctrl_reg_q[NC_SHIFT_LO +: 5]; // [RULE20] [RULE18]
      norm_wide  = 23'sh000000;
      norm_out   = 22'sh000000;
      norm_rnd   = 1'b0;
      if (norm_shift >= 0 && norm_shift <= NORM_RIGHT_MAX) begin
         norm_wide = $signed({x_bus, 1'b0}) >>> norm_shift;            // [RULE19]
         norm_out  = norm_wide[22:1];
         norm_rnd  = norm_wide[0];
      end else if (norm_shift < 0 && -norm_shift <= NORM_LEFT_MAX) begin
         norm_out  = $signed(x_bus) <<< (-norm_shift);                 // [RULE19]
      end
   end

   // zero data unit still adds the rounding bit, limited to 22 bits
   assign out_sum = 22'(norm_out) + (norm_ctrl_reg_q[NC_ADD_Y] ? y_bus[21:0] : 22'h000000)
                    + {21'h000000, norm_rnd};                          // [RULE21]

   // byte steering onto the cascade output
   always_comb begin
      cas_d = out_sum;
      if (output_ctrl_reg_q[OC_BYTE_HI]) begin
         cas_d[21:14] = tbl_byte;                                      // [RULE22]
      end
      if (output_ctrl_reg_q[OC_BYTE_LO]) begin
         cas_d[7:0] = tbl_byte;                                        // [RULE22]
      end
   end

   // registered cascade output, one cycle after the sample
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cas_out_q   <= 22'h000000;
         out_valid_q <= 1'b0;
      end else if (clk_en_i) begin
         out_valid_q <= in_valid_i;
         if (in_valid_i) begin
            cas_out_q <= cas_d;
         end
      end
   end

   assign apb_rsp_o   = rsp_q;
   assign cas_out_o   = cas_out_q;
   assign out_valid_o = out_valid_q;

endmodule

// File: dv/bpp_backend_chk.sv
`timescale 1ns/1ps
// watches the register port and sample stream
module bpp_backend_chk (
   input wire logic                  ref_clk_i,
   input wire logic                  sys_rst_i,
   input wire logic                  clk_en_i,
   input wire bpp_pkg::bpp_apb_req_t apb_req_i,
   input wire bpp_pkg::bpp_apb_rsp_t apb_rsp_o,
   input wire logic                  in_valid_i,
   input wire logic [21:0]           cas_out_o,
   input wire logic                  out_valid_o
);
   import bpp_pkg::*;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   // unmapped addresses
   wire logic hole;
   assign hole = (apb_req_i.paddr > OFF_PRESC_CTRL && apb_req_i.paddr < OFF_LUT_BASE) || apb_req_i.paddr > OFF_LUT_LAST;
   a_sample_out: assert property (in_valid_i && clk_en_i |=> out_valid_o)
      else $error("no output after a sample");
   a_idle_quiet: assert property (!in_valid_i && clk_en_i |=> !out_valid_o)
      else $error("output valid without a sample");
   a_out_holds: assert property (!in_valid_i && clk_en_i |=> $stable(cas_out_o))
      else $error("output moved without a sample");
   a_ready_pulse: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
      else $error("ready longer than one cycle");
   a_ready_time: assert property (apb_req_i.psel && apb_req_i.penable && !$past(apb_req_i.penable) && clk_en_i
      |-> !apb_rsp_o.pready ##1 apb_rsp_o.pready)
      else $error("ready not on second access cycle");
   a_ready_access: assert property (apb_rsp_o.pready |-> apb_req_i.psel && apb_req_i.penable)
      else $error("ready outside an access phase");
   a_hole_err: assert property (apb_rsp_o.pready && hole |-> apb_rsp_o.pslverr)
      else $error("unmapped address without error");
   a_map_ok: assert property (apb_rsp_o.pready && !hole |-> !apb_rsp_o.pslverr)
      else $error("error on a mapped address");
   a_write_rdata: assert property (apb_rsp_o.pready && apb_req_i.pwrite |-> apb_rsp_o.prdata == 32'h0)
      else $error("read data on a write");
endmodule

bind bpp_backend bpp_backend_chk u_bpp_backend_chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
   .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .in_valid_i(in_valid_i), .cas_out_o(cas_out_o),
   .out_valid_o(out_valid_o));

// File: dv/bpp_mac_model.sv
`timescale 1ns/1ps
// mac array and upstream neighbour; junk between samples
module bpp_mac_model (
   input  wire logic  ref_clk_i,
   output logic [21:0] mac_data_o,
   output logic [21:0] cas_data_o,
   output logic        valid_o
);
   initial begin
      mac_data_o = 22'h0;
      cas_data_o = 22'h0;
      valid_o    = 1'b0;
   end
   // one sample per call, valid for one edge
   task automatic send(input logic [21:0] m, input logic [21:0] c);
      @(posedge ref_clk_i);
      mac_data_o <= m;
      cas_data_o <= c;
      valid_o    <= 1'b1;
      @(posedge ref_clk_i);
      mac_data_o <= ~m;
      cas_data_o <= ~c;
      valid_o    <= 1'b0;
   endtask
endmodule

// File: dv/test_bpp_backend.sv
`timescale 1ns/1ps
module test_bpp_backend;
   import bpp_pkg::*;
   typedef struct packed {
      logic [7:0]  ic;
      logic [7:0]  nc;
      logic [21:0] mac;
      logic [21:0] cas;
      logic [21:0] res;
   } bpp_row_t;
   logic         ref_clk_i;
   logic         sys_rst_i;
   bpp_apb_req_t req;
   bpp_apb_rsp_t rsp;
   logic [21:0]  mac;
   logic [21:0]  cas;
   logic         vld;
   logic [21:0]  cas_out;
   logic         out_vld;
   int           fail_count;
   int           num_checks;
   bpp_row_t     rows [12];
   // clock enable tied high
   bpp_backend u_bpp_backend (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .apb_req_i(req),
      .apb_rsp_o(rsp), .mac_data_i(mac), .cas_in_i(cas), .in_valid_i(vld), .cas_out_o(cas_out), .out_valid_o(out_vld));
   bpp_mac_model u_bpp_mac_model (.ref_clk_i(ref_clk_i), .mac_data_o(mac), .cas_data_o(cas), .valid_o(vld));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_out(input logic [21:0] e);
      num_checks++;
      if ({out_vld, cas_out} !== {1'b1, e}) begin
         fail_count++;
         $display("[ERR] cas_out expected %h seen %h", e, cas_out);
      end
   endtask
   // one apb transfer; bounded wait for ready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
      int n;
      @(posedge ref_clk_i);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge ref_clk_i);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (rsp.pready !== 1'b1 && n < 16);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req <= '0;
      if (rsp.pready !== 1'b1) begin
         fail_count++;
         $display("[ERR] pready expected 1 seen none");
         end_sim();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic chk(input logic [11:0] a, input logic [31:0] d, input logic e);
      logic [31:0] r;
      logic        er;
      apb(1'b0, a, 32'h0, r, er);
      cmp_reg("prdata", d, r);
      cmp_reg("pslverr", {31'h0, e}, {31'h0, er});
   endtask
   // snapshot into the buffers and read them
   task automatic snap(input logic [31:0] t, input logic [31:0] c);
      wr(OFF_CNT_COPY, 32'h0);
      chk(OFF_THR_BUFFER, t, 1'b0);
      chk(OFF_CNT_BUFFER, c, 1'b0);
   endtask
   task automatic feed(input logic [21:0] m, input logic [21:0] c);
      u_bpp_mac_model.send(m, c);
      #1;
   endtask
   task automatic lut(input logic [7:0] oc, input logic [7:0] nc, input logic [21:0] m, input logic [21:0] e);
      wr(OFF_OUTPUT_CTRL, {24'h0, oc});
      wr(OFF_NORM_CTRL, {24'h0, nc});
      feed(m, 22'h0);
      cmp_out(e);
   endtask
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      sys_rst_i  = 1'b1;
      req        = '0;
      fail_count = 0;
      num_checks = 0;
      // ic, nc, sample, cascade in, expected
      rows = '{'{8'h01, 8'h00, 22'h000064, 22'h000017, 22'h00007B}, '{8'h00, 8'h00, 22'h000064, 22'h000017, 22'h000064},
         '{8'h05, 8'h00, 22'h000003, 22'h0, 22'h00000C}, '{8'h3D, 8'h00, 22'h000007, 22'h0, 22'h000002},
         '{8'h31, 8'h00, 22'h000180, 22'h0, 22'h000002}, '{8'h41, 8'h00, 22'h3FFFFB, 22'h0, 22'h000005},
         '{8'h81, 8'h00, 22'h3FFFFB, 22'h0, 22'h000000}, '{8'h41, 8'h00, 22'h200000, 22'h0, 22'h200000},
         '{8'h01, 8'h48, 22'h000300, 22'h0, 22'h000002}, '{8'h01, 8'hF0, 22'h000005, 22'h0, 22'h000014},
         '{8'h01, 8'h78, 22'h0003E8, 22'h0, 22'h000000}, '{8'h01, 8'hE8, 22'h000005, 22'h0, 22'h000000}};
      repeat (12) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      #1 cmp_reg("out", 32'h0, {9'h0, out_vld, cas_out});
      chk(OFF_ACCESS_CTRL, 32'h2, 1'b0);
      chk(12'h030, 32'h0, 1'b1);
      foreach (rows[i]) begin
         wr(OFF_INPUT_CTRL, {24'h0, rows[i].ic});
         wr(OFF_NORM_CTRL, {24'h0, rows[i].nc});
         feed(rows[i].mac, rows[i].cas);
         cmp_out(rows[i].res);
      end
      snap(32'h200000, 32'h0);
      $display("test datapath rows done");
      wr(OFF_INPUT_CTRL, 32'h1);
      wr(OFF_NORM_CTRL, 32'h0);
      wr(OFF_STATS_CTRL, 32'h1);
      feed(22'h000005, 22'h0);
      feed(22'h000003, 22'h0);
      feed(22'h000009, 22'h0);
      snap(32'h000009, 32'h2);
      feed(22'h200000, 22'h3FFFFF);
      snap(32'h800009, 32'h2);
      wr(OFF_THR_BUFFER, 32'h0);
      wr(OFF_THR_COPY, 32'h0);
      snap(32'h0, 32'h2);
      wr(OFF_STATS_CTRL, 32'h3);
      wr(OFF_CNT_BUFFER, 32'hFFFD);
      wr(OFF_CNT_COPY, 32'h1);
      feed(22'h000001, 22'h0);
      feed(22'h1FFFFF, 22'h000001);
      snap(32'h400000, 32'hFFFF);
      feed(22'h000001, 22'h0);
      snap(32'h400000, 32'hFFFF);
      wr(OFF_STATS_CTRL, 32'h2);
      wr(OFF_CNT_BUFFER, 32'h0);
      wr(OFF_CNT_COPY, 32'h1);
      feed(22'h3FFFFF, 22'h0);
      feed(22'h000005, 22'h0);
      snap(32'h400000, 32'h1);
      $display("test statistics done");
      wr(OFF_INPUT_CTRL, 32'h1);
      wr(OFF_ACCESS_CTRL, 32'h0);
      wr(OFF_LUT_BASE, 32'h44332211);
      wr(OFF_UPPER_SAT, 32'hAA000000);
      wr(OFF_LOWER_SAT, 32'h55000000);
      chk(OFF_LUT_BASE, 32'h44332211, 1'b0);
      wr(OFF_ACCESS_CTRL, 32'h2);
      chk(OFF_LUT_BASE, 32'h0, 1'b0);
      lut(8'h40, 8'h00, 22'h000001, 22'h000022);
      lut(8'h40, 8'h00, 22'h00012C, 22'h0001AA);
      lut(8'h40, 8'h00, 22'h3FFED4, 22'h3FFE55);
      lut(8'h20, 8'h00, 22'h000002, 22'h0CC002);
      lut(8'h00, 8'h06, 22'h000001, 22'h332211);
      lut(8'h00, 8'h02, 22'h000001, 22'h332212);
      wr(OFF_PRESC_CTRL, 32'h4);
      lut(8'h40, 8'h00, 22'h000030, 22'h000044);
      $display("test table done");
      @(posedge ref_clk_i);
      sys_rst_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      #1 cmp_reg("out", 32'h0, {9'h0, out_vld, cas_out});
      chk(OFF_ACCESS_CTRL, 32'h2, 1'b0);
      chk(OFF_OUTPUT_CTRL, 32'h0, 1'b0);
      $display("test second reset done");
      end_sim();
   end
endmodule
